// [core/cgsmb_regs.vh]
`ifndef CGSMB_REGS_VH
`define CGSMB_REGS_VH

// register indices (byte numbers on the serial bus)
`define CGSMB_IDX_SPREAD_SWING 8'h01
`define CGSMB_IDX_DIFF_EDGE 8'h02
`define CGSMB_IDX_REF_CTRL 8'h03
`define CGSMB_IDX_RSVD_ONES 8'h04
`define CGSMB_IDX_REV_MAKER 8'h05
`define CGSMB_IDX_FAMILY_PART 8'h06
`define CGSMB_IDX_READBACK_LEN 8'h07

// field positions
`define CGSMB_B1_STRAP_HI 7
`define CGSMB_B1_STRAP_LO 6
`define CGSMB_B1_OVERRIDE 5
`define CGSMB_B1_SEL_HI 4
`define CGSMB_B1_SEL_LO 3
`define CGSMB_B1_AMP_HI 1
`define CGSMB_B1_AMP_LO 0
`define CGSMB_B2_OUT1_EDGE 2
`define CGSMB_B2_OUT0_EDGE 1
`define CGSMB_B3_REF_EDGE_HI 7
`define CGSMB_B3_REF_EDGE_LO 6
`define CGSMB_B3_REF_WOL 5
`define CGSMB_B3_REF_OE 4
`define CGSMB_B7_LEN_HI 4
`define CGSMB_B7_LEN_LO 0

// reset values
`define CGSMB_RST_OVERRIDE 1'b0
`define CGSMB_RST_SEL 2'h0
`define CGSMB_RST_AMP 2'h2
`define CGSMB_RST_OUT_EDGE 1'b1
`define CGSMB_RST_REF_EDGE 2'h1
`define CGSMB_RST_REF_WOL 1'b0
`define CGSMB_RST_REF_OE 1'b1
`define CGSMB_RST_LEN 5'h08
`define CGSMB_RSVD_BYTE 8'hff
`define CGSMB_UNMAPPED_BYTE 8'h00

// strap levels and spread encodings
`define CGSMB_STRAP_LOW 2'h0
`define CGSMB_STRAP_MID 2'h1
`define CGSMB_STRAP_HIGH 2'h3
`define CGSMB_SPREAD_OFF 2'h0
`define CGSMB_SPREAD_QUARTER 2'h1
`define CGSMB_SPREAD_RSVD 2'h2
`define CGSMB_SPREAD_HALF 2'h3

// default bus address (1101000)
`define CGSMB_DEF_ADDR 7'h68

`endif

// [core/cgsmb_sync.v]
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for levels from outside the clock domain
module cgsmb_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input wire clock,
  input wire resetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  always @(posedge clock) begin
    if (!resetn) begin
      stage1 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

`default_nettype wire

// [core/cgsmb_edge.v]
`timescale 1ns/1ps
`default_nettype none

// edge finder on an already synchronised level
module cgsmb_edge (
  input wire clock,
  input wire resetn,
  input wire level,
  output wire rise,
  output wire fall
);

  reg prev;

  always @(posedge clock) begin
    if (!resetn) begin
      prev <= 1'b1;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule

`default_nettype wire

// [core/cgsmb_config_regs.v]
// Summary of operation
// - The top two bits of byte 1 read back the latched three-level spread strap as 00, 01 or 11.
// - Byte 1 bit 5 picks the spread source: 0 follows the strap, 1 uses bits 4:3, and it resets to 0.
// - Byte 1 bits 4:3 mean off, -0.25%, reserved, -0.5% and reset to 00.
// - The software spread select has no effect unless the override bit is 1.
// - Byte 1 bits 1:0 choose a swing of 0.6V, 0.7V, 0.8V or 0.9V and reset to 10.
// - Byte 2 bits 2 and 1 set the edge rate of outputs 1 and 0, 0 for 2.0V/ns, 1 for 3.0V/ns, both resetting to 1.
// - Byte 3 bits 7:6 choose the reference edge rate from slowest to faster and reset to 01.
// - Byte 3 bit 5 keeps the reference running in power down when 1 and stops it when 0, resetting to 0.
// - Byte 3 bit 4 enables the reference output, which is held low when the bit is 0, and it resets to 1.
// - Byte 4 is reserved and always reads all ones.
// - Byte 5 is read-only with a fixed revision code high and a fixed maker code low.
// - Byte 6 is read-only with a fixed two-bit family code high and a six-bit part code low.
// - Byte 7 bits 4:0 set the number of bytes a block read returns, resetting to 8 and rewritable by the host.
// - A block write is start, write address, index N, count X, bytes N to N+X-1, stop, each byte acknowledged.
// - A block read is index write, repeated start, read address, then the count byte and data, ended by the host's no-ack.
`timescale 1ns/1ps
`default_nettype none
`include "cgsmb_regs.vh"

module cgsmb_config_regs #(
  parameter [6:0] BUS_ADDR = `CGSMB_DEF_ADDR,
  parameter [3:0] REVISION_CODE = 4'h3,   // arbitrary value
  parameter [3:0] MAKER_CODE = 4'h9,      // arbitrary value
  parameter [1:0] FAMILY_TYPE_CODE = 2'h2,  // arbitrary value
  parameter [5:0] PART_CODE = 6'h15       // arbitrary value
) (
  input wire clock,
  input wire resetn,
  input wire smb_clock,
  input wire smb_data_in,
  output reg smb_data_out,
  output reg smb_data_oe,
  input wire [1:0] spread_strap_level,
  input wire power_down,
  output reg [1:0] spread_amount,
  output reg [1:0] output_swing,
  output reg out1_edge_rate_sel,
  output reg out0_edge_rate_sel,
  output reg [1:0] ref_edge_rate,
  output reg ref_run_in_power_down,
  output reg ref_output_enable,
  output reg ref_clock_run
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edges

  wire scl;
  wire sda;
  wire [1:0] strap_sync;
  wire pd_sync;
  wire scl_rise;
  wire scl_fall;
  wire sda_rise;
  wire sda_fall;

  cgsmb_sync #(.WIDTH(2), .INIT(2'h3)) u_sync_bus (
    .clock(clock),
    .resetn(resetn),
    .async_in({smb_clock, smb_data_in}),
    .sync_out({scl, sda})
  );

  // free-running so the strap is already settled at the first edge after reset
  cgsmb_sync #(.WIDTH(3), .INIT(3'h0)) u_sync_misc (
    .clock(clock),
    .resetn(1'b1),
    .async_in({spread_strap_level, power_down}),
    .sync_out({strap_sync, pd_sync})
  );

  cgsmb_edge u_edge_scl (
    .clock(clock),
    .resetn(resetn),
    .level(scl),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  cgsmb_edge u_edge_sda (
    .clock(clock),
    .resetn(resetn),
    .level(sda),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  wire start_cond = sda_fall & scl;
  wire stop_cond = sda_rise & scl;

  //////////////////////////////////////////////////////////////////////////////
  // register fields

  reg [1:0] strap_latched;
  reg strap_taken;
  reg sw_override;
  reg [1:0] sw_select;
  reg [1:0] swing;
  reg edge1;
  reg edge0;
  reg [1:0] ref_edge;
  reg ref_wol;
  reg ref_oe;
  reg [4:0] readback_len;

  // strap is caught by the first clock after reset release, then held
  always @(posedge clock) begin
    if (!resetn) begin
      strap_latched <= `CGSMB_STRAP_LOW;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      strap_latched <= {strap_sync[1], |strap_sync};
    end
  end

  // read multiplexer
  reg [7:0] index;
  reg [7:0] read_byte;

  always @* begin
    read_byte = `CGSMB_UNMAPPED_BYTE;
    case (index)
      `CGSMB_IDX_SPREAD_SWING: begin
        read_byte = {strap_latched, sw_override, sw_select, 1'b1, swing};
      end
      `CGSMB_IDX_DIFF_EDGE: begin
        read_byte = {5'h1f, edge1, edge0, 1'b1};
      end
      `CGSMB_IDX_REF_CTRL: begin
        read_byte = {ref_edge, ref_wol, ref_oe, 4'hf};
      end
      `CGSMB_IDX_RSVD_ONES: begin
        read_byte = `CGSMB_RSVD_BYTE;
      end
      `CGSMB_IDX_REV_MAKER: begin
        read_byte = {REVISION_CODE, MAKER_CODE};
      end
      `CGSMB_IDX_FAMILY_PART: begin
        read_byte = {FAMILY_TYPE_CODE, PART_CODE};
      end
      `CGSMB_IDX_READBACK_LEN: begin
        read_byte = {3'h0, readback_len};
      end
      default: begin
        read_byte = `CGSMB_UNMAPPED_BYTE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial slave state machine

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_INDEX = 3'h2;
  localparam [2:0] ST_COUNT = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [2:0] ST_WAIT = 3'h6;

  reg [2:0] state;
  reg [3:0] bit_count;
  reg in_ack;
  reg addr_read;
  reg [7:0] shift;
  reg [7:0] write_left;
  reg [5:0] read_left;
  reg first_write;
  reg host_acked;

  wire receiving = (state == ST_ADDR) || (state == ST_INDEX) || (state == ST_COUNT) || (state == ST_WDATA);

  always @(posedge clock) begin
    if (!resetn) begin
      state <= ST_IDLE;
      bit_count <= 4'h0;
      in_ack <= 1'b0;
      addr_read <= 1'b0;
      shift <= 8'h00;
      index <= 8'h00;
      write_left <= 8'h00;
      read_left <= 6'h00;
      first_write <= 1'b0;
      host_acked <= 1'b0;
      smb_data_out <= 1'b0;
      smb_data_oe <= 1'b0;
      sw_override <= `CGSMB_RST_OVERRIDE;
      sw_select <= `CGSMB_RST_SEL;
      swing <= `CGSMB_RST_AMP;
      edge1 <= `CGSMB_RST_OUT_EDGE;
      edge0 <= `CGSMB_RST_OUT_EDGE;
      ref_edge <= `CGSMB_RST_REF_EDGE;
      ref_wol <= `CGSMB_RST_REF_WOL;
      ref_oe <= `CGSMB_RST_REF_OE;
      readback_len <= `CGSMB_RST_LEN;
    end else begin
      smb_data_out <= 1'b0;
      if (start_cond) begin
        // start or repeated start; index is kept for the read phase
        state <= ST_ADDR;
        bit_count <= 4'h0;
        in_ack <= 1'b0;
        smb_data_oe <= 1'b0;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        in_ack <= 1'b0;
        smb_data_oe <= 1'b0;
      end else if (receiving) begin
        if (scl_rise && !in_ack) begin
          shift <= {shift[6:0], sda};
          bit_count <= bit_count + 4'h1;
        end else if (scl_fall && !in_ack && bit_count == 4'h8) begin
          // eighth bit done: decide and drive the acknowledge
          in_ack <= 1'b1;
          case (state)
            ST_ADDR: begin
              if (shift[7:1] == BUS_ADDR) begin
                smb_data_oe <= 1'b1;
                addr_read <= shift[0];
              end else begin
                state <= ST_WAIT;
              end
            end
            ST_INDEX: begin
              smb_data_oe <= 1'b1;
              index <= shift;
            end
            ST_COUNT: begin
              smb_data_oe <= 1'b1;
              write_left <= shift;
            end
            ST_WDATA: begin
              smb_data_oe <= 1'b1;
              write_left <= write_left - 8'h01;
              case (index)
                `CGSMB_IDX_SPREAD_SWING: begin
                  sw_override <= shift[`CGSMB_B1_OVERRIDE];
                  sw_select <= shift[`CGSMB_B1_SEL_HI:`CGSMB_B1_SEL_LO];
                  swing <= shift[`CGSMB_B1_AMP_HI:`CGSMB_B1_AMP_LO];
                end
                `CGSMB_IDX_DIFF_EDGE: begin
                  edge1 <= shift[`CGSMB_B2_OUT1_EDGE];
                  edge0 <= shift[`CGSMB_B2_OUT0_EDGE];
                end
                `CGSMB_IDX_REF_CTRL: begin
                  ref_edge <= shift[`CGSMB_B3_REF_EDGE_HI:`CGSMB_B3_REF_EDGE_LO];
                  ref_wol <= shift[`CGSMB_B3_REF_WOL];
                  ref_oe <= shift[`CGSMB_B3_REF_OE];
                end
                `CGSMB_IDX_READBACK_LEN: begin
                  readback_len <= shift[`CGSMB_B7_LEN_HI:`CGSMB_B7_LEN_LO];
                end
                default: begin
                  // read-only and reserved bytes take no write
                  readback_len <= readback_len;
                end
              endcase
              index <= index + 8'h01;
            end
            default: begin
              in_ack <= 1'b1;
            end
          endcase
        end else if (scl_fall && in_ack) begin
          // end of the acknowledge clock: release and move on
          in_ack <= 1'b0;
          bit_count <= 4'h0;
          smb_data_oe <= 1'b0;
          case (state)
            ST_ADDR: begin
              if (addr_read) begin
                // first byte out is the count
                state <= ST_RDATA;
                shift <= {3'h0, readback_len};
                read_left <= {1'b0, readback_len};
                first_write <= 1'b1;
                smb_data_oe <= 1'b1;
              end else begin
                state <= ST_INDEX;
              end
            end
            ST_INDEX: begin
              state <= ST_COUNT;
            end
            ST_COUNT: begin
              state <= (write_left == 8'h00) ? ST_WAIT : ST_WDATA;
            end
            default: begin
              state <= (write_left == 8'h00) ? ST_WAIT : ST_WDATA;
            end
          endcase
        end
      end else if (state == ST_RDATA) begin
        if (!in_ack) begin
          if (scl_rise) begin
            bit_count <= bit_count + 4'h1;
          end else if (scl_fall) begin
            if (bit_count == 4'h8) begin
              in_ack <= 1'b1;
              smb_data_oe <= 1'b0;
              if (!first_write) begin
                index <= index + 8'h01;
              end
            end else begin
              shift <= {shift[6:0], 1'b1};
              smb_data_oe <= ~shift[6];
            end
          end
        end else begin
          if (scl_rise) begin
            host_acked <= ~sda;
          end else if (scl_fall) begin
            in_ack <= 1'b0;
            bit_count <= 4'h0;
            first_write <= 1'b0;
            if (!host_acked || read_left == 6'h00) begin
              state <= ST_WAIT;
              smb_data_oe <= 1'b0;
            end else begin
              read_left <= read_left - 6'h01;
              shift <= read_byte;
              smb_data_oe <= ~read_byte[7];
            end
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered field outputs

  always @(posedge clock) begin
    if (!resetn) begin
      spread_amount <= `CGSMB_SPREAD_OFF;
      output_swing <= `CGSMB_RST_AMP;
      out1_edge_rate_sel <= `CGSMB_RST_OUT_EDGE;
      out0_edge_rate_sel <= `CGSMB_RST_OUT_EDGE;
      ref_edge_rate <= `CGSMB_RST_REF_EDGE;
      ref_run_in_power_down <= `CGSMB_RST_REF_WOL;
      ref_output_enable <= `CGSMB_RST_REF_OE;
      ref_clock_run <= 1'b0;
    end else begin
      if (sw_override) begin
        spread_amount <= sw_select;
      end else begin
        spread_amount <= strap_latched;
      end
      output_swing <= swing;
      out1_edge_rate_sel <= edge1;
      out0_edge_rate_sel <= edge0;
      ref_edge_rate <= ref_edge;
      ref_run_in_power_down <= ref_wol;
      ref_output_enable <= ref_oe;
      ref_clock_run <= ref_oe & (~pd_sync | ref_wol);
    end
  end

endmodule

`default_nettype wire

// [bench/cgsmb_props.sv]
`timescale 1ns/1ps
`default_nettype none
module cgsmb_props (
  input wire clock,
  input wire resetn,
  input wire smb_data_out,
  input wire smb_data_oe,
  input wire [1:0] spread_strap_level,
  input wire power_down,
  input wire [1:0] spread_amount,
  input wire [1:0] output_swing,
  input wire out1_edge_rate_sel,
  input wire out0_edge_rate_sel,
  input wire [1:0] ref_edge_rate,
  input wire ref_run_in_power_down,
  input wire ref_output_enable,
  input wire ref_clock_run
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  AST_OPEN_DRAIN: assert property (smb_data_out == 1'b0)
    else $error("data pin driven high");
  AST_RST_SWING: assert property (@(posedge clock) disable iff (1'b0) !resetn |=> output_swing == 2'h2)
    else $error("swing not at default in reset");
  AST_RST_EDGE: assert property (@(posedge clock) disable iff (1'b0)
    !resetn |=> out1_edge_rate_sel && out0_edge_rate_sel) else $error("edge rates not at default");
  AST_RST_REF: assert property (@(posedge clock) disable iff (1'b0) !resetn |=>
    ref_edge_rate == 2'h1 && !ref_run_in_power_down && ref_output_enable) else $error("ref fields not at default");
  AST_RST_BUS: assert property (@(posedge clock) disable iff (1'b0)
    !resetn |=> !smb_data_oe && !ref_clock_run) else $error("outputs active in reset");
  AST_STRAP_MAP: assert property ($rose(resetn) |->
    ##3 (spread_amount == {spread_strap_level[1], |spread_strap_level})[*4]) else $error("strap spread wrong");
  AST_STRAP_HOLD: assert property ($changed(spread_strap_level) |=> $stable(spread_amount)[*4])
    else $error("strap recaptured mid run");
  AST_REF_LOW: assert property ((!ref_output_enable)[*2] |-> !ref_clock_run)
    else $error("disabled reference running");
  AST_PD_STOP: assert property ((power_down && !ref_run_in_power_down)[*8] |-> !ref_clock_run)
    else $error("reference runs in power down");
  AST_PD_RUN: assert property ((!power_down && ref_output_enable)[*8] |-> ref_clock_run)
    else $error("enabled reference stopped");
  AST_ACK_HOLD: assert property ($rose(smb_data_oe) |-> smb_data_oe[*6])
    else $error("data pull too short");
  cover property ($rose(smb_data_oe));
  cover property ($fell(ref_clock_run));
  cover property (spread_amount == 2'h3);
endmodule
`default_nettype wire

// [bench/cgsmb_host.sv]
`timescale 1ns/1ps
`default_nettype none
module cgsmb_host (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic res_valid,
  output logic [7:0] res_data
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_valid = 1'b0;
    res_data = 8'h00;
  end
  task tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // data moves only while the bus clock is low
  task bit_io(input logic b, output logic s);
    scl = 1'b0;
    tick(2);
    sda_low = !b;
    tick(2);
    scl = 1'b1;
    tick(3);
    s = sda;
    tick(1);
  endtask
  task start;
    scl = 1'b0;
    tick(2);
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
  endtask
  task stop;
    scl = 1'b0;
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask
  // msb first, then the acknowledge slot; reports the byte or the ack seen
  task xfer(input logic [7:0] d, input logic nak, input logic rd);
    logic [7:0] q;
    logic a;
    int i;
    for (i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(nak, a);
    res_data = rd ? q : {7'h00, a};
    res_valid = 1'b1;
    tick(1);
    res_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cgsmb_regs.vh"
module tb_top;
  localparam [3:0] TB_REV = 4'h6; // arbitrary value
  localparam [3:0] TB_MAKER = 4'ha; // arbitrary value
  localparam [1:0] TB_FAMILY = 2'h1; // arbitrary value
  localparam [5:0] TB_PART = 6'h2c; // arbitrary value
  logic clock, resetn, power_down, snap, scl, sda_low, res_valid;
  logic [1:0] strap, strap_cap;
  logic [7:0] res_data;
  logic [7:0] mdl [1:7];
  logic [7:0] w [0:7];
  logic [7:0] exp_q [$];
  logic [10:0] port_q [$];
  int err_total, checks_done, cyc, i, k;
  wire sda, d_out, d_oe, out1, out0, wol, ref_oe, ref_run;
  wire [1:0] spread, swing, ref_edge;
  assign sda = !sda_low && !(d_oe && !d_out);
  cgsmb_config_regs #(.REVISION_CODE(TB_REV), .MAKER_CODE(TB_MAKER), .FAMILY_TYPE_CODE(TB_FAMILY),
    .PART_CODE(TB_PART)) DUT (.clock(clock), .resetn(resetn), .smb_clock(scl), .smb_data_in(sda),
    .smb_data_out(d_out), .smb_data_oe(d_oe), .spread_strap_level(strap), .power_down(power_down),
    .spread_amount(spread), .output_swing(swing), .out1_edge_rate_sel(out1), .out0_edge_rate_sel(out0),
    .ref_edge_rate(ref_edge), .ref_run_in_power_down(wol), .ref_output_enable(ref_oe), .ref_clock_run(ref_run));
  cgsmb_host host (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low), .res_valid(res_valid),
    .res_data(res_data));
  initial begin
    clock = 1'b0;
    forever #10 clock = !clock;
  end
  task end_sim;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(posedge clock) begin
    if (res_valid === 1'b1) chk("bus_byte", {3'h0, exp_q.pop_front()}, {3'h0, res_data});
    if (snap === 1'b1) chk("ports", port_q.pop_front(), {spread, swing, out1, out0, ref_edge, wol, ref_oe, ref_run});
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      end_sim();
    end
  end
  function automatic logic [10:0] pexp();
    return {mdl[1][5] ? mdl[1][4:3] : {strap_cap[1], |strap_cap}, mdl[1][1:0], mdl[2][2:1], mdl[3][7:4],
      mdl[3][4] & (!power_down | mdl[3][5])};
  endfunction
  task pcheck;
    port_q.push_back(pexp());
    snap = 1'b1;
    @(negedge clock);
    snap = 1'b0;
  endtask
  task do_reset;
    resetn = 1'b0;
    repeat (20) @(negedge clock);
    strap_cap = strap;
    mdl[1] = {strap_cap, 6'h06};
    mdl[2] = 8'hff;
    mdl[3] = 8'h5f;
    mdl[4] = 8'hff;
    mdl[5] = {TB_REV, TB_MAKER};
    mdl[6] = {TB_FAMILY, TB_PART};
    mdl[7] = 8'h08;
    resetn = 1'b1;
    repeat (8) @(negedge clock);
  endtask
  // block write of bytes 1 to 7 from w
  task bw(input logic [6:0] a);
    host.start();
    if (a != `CGSMB_DEF_ADDR) begin
      exp_q.push_back(8'h01);
      host.xfer({a, 1'b0}, 1'b1, 1'b0);
    end else begin
      for (k = 0; k < 10; k++) exp_q.push_back(8'h00);
      host.xfer({a, 1'b0}, 1'b1, 1'b0);
      host.xfer(8'h01, 1'b1, 1'b0);
      host.xfer(8'h07, 1'b1, 1'b0);
      for (k = 1; k < 8; k++) host.xfer(w[k], 1'b1, 1'b0);
      mdl[1] = {strap_cap, w[1][5:3], 1'b1, w[1][1:0]};
      mdl[2] = {5'h1f, w[2][2:1], 1'b1};
      mdl[3] = {w[3][7:4], 4'hf};
      mdl[7] = {3'h0, w[7][4:0]};
    end
    host.stop();
  endtask
  task rd;
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    exp_q.push_back(mdl[7]);
    for (k = 0; k < 8; k++) exp_q.push_back(k >= mdl[7] ? 8'hff : (k < 7 ? mdl[k + 1] : 8'h00));
    host.start();
    host.xfer({`CGSMB_DEF_ADDR, 1'b0}, 1'b1, 1'b0);
    host.xfer(8'h01, 1'b1, 1'b0);
    host.start();
    host.xfer({`CGSMB_DEF_ADDR, 1'b1}, 1'b1, 1'b0);
    host.xfer(8'hff, 1'b0, 1'b1);
    for (k = 0; k < 8; k++) host.xfer(8'hff, k == 7, 1'b1);
    host.stop();
  endtask
  initial begin
    power_down = 1'b0;
    strap = 2'h1;
    snap = 1'b0;
    resetn = 1'b0;
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    void'($urandom(24));
    do_reset();
    pcheck();
    rd();
    for (i = 0; i < 5; i++) begin
      for (k = 0; k < 8; k++) w[k] = $urandom;
      w[1][5] = (i % 4 != 0);
      w[1][4:3] = (i % 4 == 0) ? 2'h3 : i[1:0];
      w[7][4:0] = (i == 2) ? 5'h03 : 5'h08;
      bw(`CGSMB_DEF_ADDR);
      power_down = w[0][0];
      repeat (12) @(negedge clock);
      pcheck();
      rd();
    end
    w[1] = 8'hff;
    bw(7'h69);
    pcheck();
    strap = 2'h3;
    repeat (10) @(negedge clock);
    pcheck();
    do_reset();
    pcheck();
    rd();
    end_sim();
  end
endmodule
bind cgsmb_config_regs cgsmb_props chk (.clock(clock), .resetn(resetn), .smb_data_out(smb_data_out),
  .smb_data_oe(smb_data_oe), .spread_strap_level(spread_strap_level), .power_down(power_down),
  .spread_amount(spread_amount), .output_swing(output_swing), .out1_edge_rate_sel(out1_edge_rate_sel),
  .out0_edge_rate_sel(out0_edge_rate_sel), .ref_edge_rate(ref_edge_rate),
  .ref_run_in_power_down(ref_run_in_power_down), .ref_output_enable(ref_output_enable),
  .ref_clock_run(ref_clock_run));
`default_nettype wire
